// ===== acs_pkg.sv
package acs_pkg;

	// ****************************************
	// Widths and lane layout
	// ****************************************
	localparam int ACC_W       = 40;
	localparam int LANE_W      = 16;
	localparam int UPPER_LSB   = 16;
	localparam int UPPER_W     = 24;
	localparam int LOWER_LSB   = 0;
	localparam int NUM_ACC     = 4;
	localparam int ACC_SEL_W   = 2;
	localparam int ADDR_W      = 16;
	localparam logic [ACC_W-1:0]  ACC_RESET  = 40'h00_0000_0000;
	localparam logic [LANE_W-1:0] HIST_RESET = 16'h0000;
	localparam logic [LANE_W-1:0] DIST_RESET = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_STEP  = 16'h0001;

	// ****************************************
	// Operation codes from the issue stage
	// ****************************************
	typedef enum logic [2:0] {
		OP_NONE      = 3'b000,
		OP_PLUS_MIN  = 3'b001,
		OP_MIN_PLUS  = 3'b010,
		OP_LOAD_DIST = 3'b011
	} arith_op_t;

	// Arithmetic slot: paired plus/minus or minus/plus
	typedef struct packed {
		arith_op_t             op;
		logic [ACC_SEL_W-1:0]  dst;
		logic [LANE_W-1:0]     metric_even;
		logic [LANE_W-1:0]     metric_odd;
	} arith_req_t;

	// Compare slot: dual compare-select
	typedef struct packed {
		logic                  valid;
		logic [ACC_SEL_W-1:0]  src_a;
		logic [ACC_SEL_W-1:0]  src_b;
		logic [ACC_SEL_W-1:0]  dst;
	} cmp_req_t;

	// Store slot: dual-lane store with post-increment
	typedef struct packed {
		logic                  valid;
		logic [ACC_SEL_W-1:0]  src;
		logic                  load_addr;
		logic [ADDR_W-1:0]     addr_lo;
		logic [ADDR_W-1:0]     addr_hi;
	} store_req_t;

	// Memory write port pair
	typedef struct packed {
		logic                  valid;
		logic [ADDR_W-1:0]     addr_lo;
		logic [LANE_W-1:0]     data_lo;
		logic [ADDR_W-1:0]     addr_hi;
		logic [LANE_W-1:0]     data_hi;
	} store_out_t;

endpackage

// ===== acs_lane_unit.sv
`timescale 1ns/1ps
module acs_lane_unit
	import acs_pkg::*;
(
	// Lane operands
	input  wire logic [LANE_W-1:0] lane_a,
	input  wire logic [LANE_W-1:0] lane_b,
	// Selection result
	output logic      [LANE_W-1:0] lane_max,
	output logic                   pick_b
);

	// Signed compare; ties keep the first source
	always_comb begin
		pick_b   = $signed(lane_b) > $signed(lane_a);
		lane_max = pick_b ? lane_b : lane_a;
	end

endmodule

// ===== viterbi_acs_datapath.sv
`timescale 1ns/1ps
// How it works
// - Compare-select finishes in one clock cycle
// - Plus/minus: upper even+dist, lower odd-dist
// - Minus/plus: upper even-dist, lower odd+dist
// - Even metric upper, odd lower, parallel
// - One loaded distance feeds both lanes
// - Lanewise max of two accumulators stored
// - Two 16-bit histories updated each compare
// - Upper history upper lane, lower history lower
// - Selection bits kept in sequential order
// - One store writes both lanes, post-increment
// - Compare with store, arithmetic with load
module viterbi_acs_datapath
	import acs_pkg::*;
(
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 reset_n,
	// Issue slots
	input  wire arith_req_t           arith_req,
	input  wire cmp_req_t             cmp_req,
	input  wire store_req_t           store_req,
	input  wire logic [LANE_W-1:0]    dist_load_data,
	input  wire logic                 dist_load,
	// Memory store port
	output store_out_t                store_out,
	// Decision histories and selected metrics
	output logic [LANE_W-1:0]         upper_path_decision_reg,
	output logic [LANE_W-1:0]         lower_path_decision_reg,
	output logic [ACC_W-1:0]          selected_metrics_acc
);

	// ****************************************
	// Storage
	// ****************************************
	logic [ACC_W-1:0]  acc_r [NUM_ACC];
	logic [LANE_W-1:0] distance_temp_reg;
	logic [ADDR_W-1:0] ptr_lo_r;
	logic [ADDR_W-1:0] ptr_hi_r;

	// ****************************************
	// Paired arithmetic lanes
	// ****************************************
	logic [LANE_W-1:0] up_sum;
	logic [LANE_W-1:0] up_dif;
	logic [LANE_W-1:0] lo_sum;
	logic [LANE_W-1:0] lo_dif;
	logic [UPPER_W-1:0] up_lane;
	logic [LANE_W-1:0]  lo_lane;
	logic               arith_wr;

	// Same distance for both lanes, computed side by side
	always_comb begin
		up_sum = arith_req.metric_even + distance_temp_reg;
		up_dif = arith_req.metric_even - distance_temp_reg;
		lo_sum = arith_req.metric_odd + distance_temp_reg;
		lo_dif = arith_req.metric_odd - distance_temp_reg;
		arith_wr = 1'b0;
		up_lane  = {UPPER_W{1'b0}};
		lo_lane  = {LANE_W{1'b0}};
		case (arith_req.op)
			OP_PLUS_MIN: begin
				arith_wr = 1'b1;
				up_lane  = {{8{up_sum[LANE_W-1]}}, up_sum};
				lo_lane  = lo_dif;
			end
			OP_MIN_PLUS: begin
				arith_wr = 1'b1;
				up_lane  = {{8{up_dif[LANE_W-1]}}, up_dif};
				lo_lane  = lo_sum;
			end
			default: begin
				arith_wr = 1'b0;
			end
		endcase
	end

	// ****************************************
	// Dual compare-select
	// ****************************************
	logic [LANE_W-1:0] src_a_up;
	logic [LANE_W-1:0] src_a_lo;
	logic [LANE_W-1:0] src_b_up;
	logic [LANE_W-1:0] src_b_lo;
	logic [LANE_W-1:0] max_up;
	logic [LANE_W-1:0] max_lo;
	logic              pick_up;
	logic              pick_lo;

	// Compare reads the accumulators as they stand this cycle
	always_comb begin
		src_a_up = acc_r[cmp_req.src_a][UPPER_LSB +: LANE_W];
		src_a_lo = acc_r[cmp_req.src_a][LOWER_LSB +: LANE_W];
		src_b_up = acc_r[cmp_req.src_b][UPPER_LSB +: LANE_W];
		src_b_lo = acc_r[cmp_req.src_b][LOWER_LSB +: LANE_W];
	end

	acs_lane_unit u_upper (
		.lane_a   (src_a_up),
		.lane_b   (src_b_up),
		.lane_max (max_up),
		.pick_b   (pick_up)
	);

	acs_lane_unit u_lower (
		.lane_a   (src_a_lo),
		.lane_b   (src_b_lo),
		.lane_max (max_lo),
		.pick_b   (pick_lo)
	);

	// ****************************************
	// Accumulator bank
	// ****************************************
	// Compare write wins if both slots hit one accumulator
	genvar gi;
	generate
		for (gi = 0; gi < NUM_ACC; gi++) begin : g_acc
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					acc_r[gi] <= ACC_RESET;
				end else if (cmp_req.valid
					&& cmp_req.dst == ACC_SEL_W'(gi)) begin
					acc_r[gi] <= {{8{max_up[LANE_W-1]}}, max_up,
						max_lo};
				end else if (arith_wr
					&& arith_req.dst == ACC_SEL_W'(gi)) begin
					acc_r[gi] <= {up_lane, lo_lane};
				end
			end
		end
	endgenerate

	// Distance register: own load strobe, so it can share a cycle
	// with paired arithmetic, which still sees the old distance
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			distance_temp_reg <= DIST_RESET;
		end else if (dist_load || arith_req.op == OP_LOAD_DIST) begin
			distance_temp_reg <= dist_load_data;
		end
	end

	// ****************************************
	// Decision histories
	// ****************************************
	// Separate registers keep bits linear for traceback
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			upper_path_decision_reg <= HIST_RESET;
			lower_path_decision_reg <= HIST_RESET;
		end else if (cmp_req.valid) begin
			upper_path_decision_reg <= {upper_path_decision_reg[LANE_W-2:0],
				pick_up};
			lower_path_decision_reg <= {lower_path_decision_reg[LANE_W-2:0],
				pick_lo};
		end
	end

	// Mirror of the last selected result
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			selected_metrics_acc <= ACC_RESET;
		end else if (cmp_req.valid) begin
			selected_metrics_acc <= {{8{max_up[LANE_W-1]}}, max_up, max_lo};
		end
	end

	// ****************************************
	// Dual-lane store
	// ****************************************
	logic [ADDR_W-1:0] st_lo_addr;
	logic [ADDR_W-1:0] st_hi_addr;

	// Loaded pointers apply to the same store
	always_comb begin
		st_lo_addr = store_req.load_addr ? store_req.addr_lo : ptr_lo_r;
		st_hi_addr = store_req.load_addr ? store_req.addr_hi : ptr_hi_r;
	end

	// Store reads the old accumulator, so it pairs with a new compare
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			store_out <= '0;
			ptr_lo_r  <= '0;
			ptr_hi_r  <= '0;
		end else begin
			store_out.valid <= store_req.valid;
			if (store_req.valid) begin
				store_out.addr_lo <= st_lo_addr;
				store_out.addr_hi <= st_hi_addr;
				store_out.data_lo <= acc_r[store_req.src][LOWER_LSB +: LANE_W];
				store_out.data_hi <= acc_r[store_req.src][UPPER_LSB +: LANE_W];
				ptr_lo_r <= st_lo_addr + ADDR_STEP;
				ptr_hi_r <= st_hi_addr + ADDR_STEP;
			end else if (store_req.load_addr) begin
				ptr_lo_r <= store_req.addr_lo;
				ptr_hi_r <= store_req.addr_hi;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_hist_upper_shift: assert property (@(posedge core_clk)
		disable iff (!reset_n) cmp_req.valid |=> upper_path_decision_reg
		== {$past(upper_path_decision_reg[LANE_W-2:0]),
		$signed($past(src_b_up)) > $signed($past(src_a_up))})
		else $error("upper history did not shift in pick");

	a_hist_lower_shift: assert property (@(posedge core_clk)
		disable iff (!reset_n) cmp_req.valid |=> lower_path_decision_reg
		== {$past(lower_path_decision_reg[LANE_W-2:0]),
		$signed($past(src_b_lo)) > $signed($past(src_a_lo))})
		else $error("lower history did not shift in pick");

	a_hist_lower_hold: assert property (@(posedge core_clk)
		disable iff (!reset_n) !cmp_req.valid |=> $stable(
		lower_path_decision_reg))
		else $error("lower history changed without compare");

	a_max_upper_lane: assert property (@(posedge core_clk)
		disable iff (!reset_n) cmp_req.valid |=> ($signed(
		selected_metrics_acc[UPPER_LSB +: LANE_W]) >= $signed(
		$past(src_a_up))) && ($signed(selected_metrics_acc[UPPER_LSB +:
		LANE_W]) >= $signed($past(src_b_up))))
		else $error("upper maximum wrong");

	a_max_lower_lane: assert property (@(posedge core_clk)
		disable iff (!reset_n) cmp_req.valid |=> selected_metrics_acc[
		LANE_W-1:0] == (($signed($past(src_b_lo))
		> $signed($past(src_a_lo))) ? $past(src_b_lo) : $past(src_a_lo)))
		else $error("lower maximum wrong");

	a_plus_minus_res: assert property (@(posedge core_clk)
		disable iff (!reset_n) (arith_req.op == OP_PLUS_MIN && !(cmp_req.valid
		&& cmp_req.dst == arith_req.dst)) |=> acc_r[$past(arith_req.dst)][
		LANE_W-1:0] == $past(arith_req.metric_odd) - $past(distance_temp_reg))
		else $error("plus/minus lower lane wrong");

	a_minus_plus_res: assert property (@(posedge core_clk)
		disable iff (!reset_n) (arith_req.op == OP_MIN_PLUS && !(cmp_req.valid
		&& cmp_req.dst == arith_req.dst)) |=> acc_r[$past(arith_req.dst)][
		UPPER_LSB +: LANE_W] == $past(arith_req.metric_even)
		- $past(distance_temp_reg))
		else $error("minus/plus upper lane wrong");

	a_store_ptr_incr: assert property (@(posedge core_clk)
		disable iff (!reset_n) store_req.valid |=> store_out.valid &&
		ptr_lo_r == store_out.addr_lo + ADDR_STEP &&
		ptr_hi_r == store_out.addr_hi + ADDR_STEP)
		else $error("store pointer not post-incremented");

	a_dist_load_par: assert property (@(posedge core_clk)
		disable iff (!reset_n) (dist_load || arith_req.op == OP_LOAD_DIST)
		|=> distance_temp_reg == $past(dist_load_data))
		else $error("distance load lost");

endmodule

// ===== metric_memory.sv
`timescale 1ns/1ps
// ****************************************
// Metric memory on the operand buses
// ****************************************
module metric_memory
	import acs_pkg::*;
(
	// Clock
	input  wire logic              core_clk,
	// Store port from the datapath
	input  wire store_out_t        store_out,
	// Paired metric read
	input  wire logic [6:0]        pair_idx,
	output logic      [LANE_W-1:0] metric_even,
	output logic      [LANE_W-1:0] metric_odd
);
	logic [LANE_W-1:0] mem [256];

	// Scrambled fill so that neighbouring metrics differ
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 16'(i * 40503);
		end
	end

	// Both lanes land in one cycle, so later reads see stored maxima
	// Plain always: the initial fill also writes this array
	always @(posedge core_clk) begin
		if (store_out.valid) begin
			mem[store_out.addr_lo[7:0]] <= store_out.data_lo;
			mem[store_out.addr_hi[7:0]] <= store_out.data_hi;
		end
	end

	// Consecutive words: even word to upper lane, odd word to lower
	assign metric_even = mem[{pair_idx, 1'b0}];
	assign metric_odd  = mem[{pair_idx, 1'b1}];
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
`define CHK(got, exp) check_eq(64'(got), 64'(exp))
module testbench;
	import acs_pkg::*;
	logic              core_clk, reset_n, dist_load;
	arith_req_t        arith_req;
	cmp_req_t          cmp_req;
	store_req_t        store_req;
	store_out_t        store_out;
	logic [LANE_W-1:0] dist_load_data, metric_even, metric_odd;
	logic [LANE_W-1:0] upper_path_decision_reg, lower_path_decision_reg;
	logic [ACC_W-1:0]  selected_metrics_acc;
	logic [6:0]        pair_idx;
	logic [LANE_W-1:0] hist_up, hist_lo, prev_hi, prev_lo, ptr_lo, ptr_hi;
	int                n_fail, checks_done, cycles;

	// ****************************************
	// Design and memory partner
	// ****************************************
	viterbi_acs_datapath dut (.core_clk(core_clk), .reset_n(reset_n),
		.arith_req(arith_req), .cmp_req(cmp_req), .store_req(store_req),
		.dist_load_data(dist_load_data), .dist_load(dist_load),
		.store_out(store_out),
		.upper_path_decision_reg(upper_path_decision_reg),
		.lower_path_decision_reg(lower_path_decision_reg),
		.selected_metrics_acc(selected_metrics_acc));
	metric_memory mem_model (.core_clk(core_clk), .store_out(store_out),
		.pair_idx(pair_idx), .metric_even(metric_even),
		.metric_odd(metric_odd));

	// ****************************************
	// Clock, hang guard and reporting
	// ****************************************
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Generous ceiling: a run needs about 220 cycles
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic check_eq(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ****************************************
	// One butterfly: load, two paired ops, compare with store
	// ****************************************
	task automatic butterfly(input logic [15:0] d, input logic swap,
		input logic first);
		logic [15:0] e, o, ah, al, bh, bl, mh, ml;
		logic        ph, pl;
		arith_req.op = OP_LOAD_DIST;
		dist_load_data = d;
		pair_idx = 7'($urandom);
		@(negedge core_clk);
		e = metric_even;
		o = metric_odd;
		arith_req = '{OP_PLUS_MIN, 2'd0, e, o};
		@(negedge core_clk);
		arith_req = '{OP_MIN_PLUS, 2'd1, e, o};
		// A load rides along; this op must still use the old distance
		dist_load = 1'b1;
		dist_load_data = ~d;
		@(negedge core_clk);
		// Compare now, store the previous maxima in the same cycle
		arith_req.op = OP_NONE;
		dist_load = 1'b0;
		cmp_req = '{1'b1, swap ? 2'd1 : 2'd0, swap ? 2'd0 : 2'd1, 2'd2};
		store_req = '{1'b1, 2'd2, first, 16'h0040, 16'h0080};
		ah = e + d;
		al = o - d;
		bh = e - d;
		bl = o + d;
		if (swap) begin
			{ah, al, bh, bl} = {bh, bl, ah, al};
		end
		// A tie keeps the first source
		ph = $signed(bh) > $signed(ah);
		pl = $signed(bl) > $signed(al);
		mh = ph ? bh : ah;
		ml = pl ? bl : al;
		hist_up = {hist_up[14:0], ph};
		hist_lo = {hist_lo[14:0], pl};
		if (first) begin
			ptr_lo = 16'h0040;
			ptr_hi = 16'h0080;
		end
		@(negedge core_clk);
		cmp_req = '0;
		store_req = '0;
		`CHK(selected_metrics_acc, {{8{mh[15]}}, mh, ml});
		`CHK(selected_metrics_acc, {{8{mh[15]}}, mh, ml});
		`CHK(selected_metrics_acc[15:0], ml);
		`CHK(upper_path_decision_reg, hist_up);
		`CHK(lower_path_decision_reg, hist_lo);
		`CHK(store_out.valid, 1'b1);
		`CHK({store_out.addr_lo, store_out.addr_hi},
			{ptr_lo, ptr_hi});
		`CHK({store_out.data_lo, store_out.data_hi},
			{prev_lo, prev_hi});
		ptr_lo++;
		ptr_hi++;
		prev_hi = mh;
		prev_lo = ml;
		@(negedge core_clk);
		`CHK(store_out.valid, 1'b0);
		`CHK({upper_path_decision_reg, lower_path_decision_reg},
			{hist_up, hist_lo});
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		n_fail = 0;
		checks_done = 0;
		cycles = 0;
		reset_n = 1'b0;
		arith_req = '0;
		cmp_req = '0;
		store_req = '0;
		dist_load_data = '0;
		dist_load = 1'b0;
		pair_idx = '0;
		{prev_hi, prev_lo, hist_up, hist_lo, ptr_lo, ptr_hi} = '0;
		void'($urandom(32'hbd231dad));
		repeat (5) @(negedge core_clk);
		reset_n = 1'b1;
		// Outputs still hold their reset values here
		`CHK(selected_metrics_acc, ACC_RESET);
		`CHK({upper_path_decision_reg, lower_path_decision_reg},
			{HIST_RESET, HIST_RESET});
		`CHK(store_out.valid, 1'b0);
		// Zero distance forces ties; half range forces wrap
		butterfly(16'h0000, 1'b0, 1'b1);
		butterfly(16'h8000, 1'b1, 1'b0);
		$display("corner butterflies done");
		for (int i = 0; i < 40; i++) begin
			butterfly(16'($urandom), 1'($urandom), 1'b0);
		end
		$display("random butterflies done");
		final_report();
	end
endmodule
